// *** verilog/cpu_core_status_and_timing.sv ***
// cpu core: register array, alu status, multiply, divide, repeat and exception entry
`timescale 1ns/1ps
`include "core_consts.svh"
module cpu_core_status_and_timing (
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  input  wire logic                op_valid_in,
  input  wire logic [3:0]          op_code_in,
  input  wire logic                byte_mode_in,
  input  wire logic                wide_div_in,
  input  wire logic [3:0]          dst_sel_in,
  input  wire logic [3:0]          src_a_sel_in,
  input  wire logic [3:0]          src_b_sel_in,
  input  wire logic                src_b_mem_in,
  input  wire logic                dst_mem_in,
  input  wire logic                offset_en_in,
  input  wire logic [15:0]         mem_rdata_in,
  input  wire logic [`IP_W-1:0]    branch_target_in,
  input  wire logic                sr_wr_in,
  input  wire logic [15:0]         sr_wdata_in,
  input  wire logic                nesting_disable_in,
  input  wire logic                priority_extend_in,
  input  wire logic                psv_enable_in,
  input  wire logic                prog_window_page_wr_in,
  input  wire logic [7:0]          prog_window_page_in,
  input  wire logic [7:0]          trap_req_in,
  input  wire logic                irq_req_in,
  input  wire logic [6:0]          irq_src_in,
  input  wire logic [2:0]          irq_level_in,
  output logic [`IP_W-1:0]         instruction_pointer_out,
  output logic [15:0]              alu_status_flags_out,
  output logic [15:0]              stack_pointer_out,
  output logic [15:0]              result_out,
  output logic [15:0]              mem_addr_out,
  output logic                     mem_we_out,
  output logic [15:0]              mem_wdata_out,
  output logic                     psv_hit_out,
  output logic [`IP_W-1:0]         psv_prog_addr_out,
  output logic [3:0]               eff_priority_out,
  output logic                     user_irq_disable_out,
  output logic                     stall_out,
  output logic                     trap_ack_out,
  output logic                     irq_ack_out
);
  logic [15:0]              w_reg [16];
  logic [15:0]              w_next [16];
  logic [15:0]              w_we;
  logic [`IP_W-1:0]         ip_reg;
  logic [8:0]               flag_reg;
  logic [2:0]               ipl_reg;
  logic                     rpt_active_reg;
  logic [15:0]              rpt_cnt_reg;
  logic [7:0]               page_reg;
  core_pkg::exec_state_t    ex_state_reg;
  core_pkg::op_t            op;
  logic [15:0] opa, opb, bx, res16, ea;
  logic [16:0] sum_w;
  logic [8:0]  sum_b;
  logic [4:0]  sum_n;
  logic        cin, is_sub, is_arith, is_chain, is_mul, is_div, is_logic;
  logic        r_msb, a_msb, b_msb, r_zero;
  logic [16:0] mul_a, mul_b;
  logic [33:0] prod;
  logic        go, trap_take, irq_take, push, div_done;
  logic [2:0]  trap_idx;
  logic [15:0] div_q, div_r;
  logic [31:0] div_num;
  logic [8:0]  flags_next;
  logic [3:0]  eff_ipl;
  logic        users_off;

  assign op = core_pkg::op_t'(op_code_in);
  assign eff_ipl   = {priority_extend_in, ipl_reg};
  assign users_off = priority_extend_in | (ipl_reg == `IPL_USER_OFF);

  // exception arbitration: traps ignore priority, lowest index first
  always_comb begin
    trap_idx = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (trap_req_in[k]) begin
        trap_idx = 3'(k);
      end
    end
  end
  assign trap_take = |trap_req_in;
  assign irq_take  = ~trap_take & irq_req_in & ~users_off & (irq_src_in < `IRQ_SRC_COUNT)
                   & ({1'b0, irq_level_in} > eff_ipl);
  assign go = op_valid_in & (ex_state_reg == core_pkg::EX_RUN) & ~trap_take & ~irq_take;

  // operands and alu
  always_comb begin
    opa      = w_reg[src_a_sel_in];
    opb      = src_b_mem_in ? mem_rdata_in : w_reg[src_b_sel_in];
    is_sub   = (op == core_pkg::OP_SUB) | (op == core_pkg::OP_SUBB);
    is_chain = (op == core_pkg::OP_ADDC) | (op == core_pkg::OP_SUBB);
    is_arith = (op_code_in[3:2] == 2'b00);
    is_logic = (op_code_in[3:2] == 2'b01);
    is_mul   = (op_code_in[3:2] == 2'b10);
    is_div   = (op == core_pkg::OP_DIV_U) | (op == core_pkg::OP_DIV_S);
    bx       = is_sub ? ~opb : opb;
    cin      = is_chain ? flag_reg[`SR_C_BIT] : is_sub;
    sum_w    = {1'b0, opa} + {1'b0, bx} + {16'h0000, cin};
    sum_b    = {1'b0, opa[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin};
    sum_n    = {1'b0, opa[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    unique case (op)
      core_pkg::OP_AND: res16 = opa & opb;
      core_pkg::OP_IOR: res16 = opa | opb;
      core_pkg::OP_XOR: res16 = opa ^ opb;
      core_pkg::OP_MOV: res16 = opb;
      default:          res16 = sum_w[15:0];
    endcase
    r_msb  = byte_mode_in ? res16[7] : res16[15];
    a_msb  = byte_mode_in ? opa[7] : opa[15];
    b_msb  = byte_mode_in ? bx[7] : bx[15];
    r_zero = byte_mode_in ? (res16[7:0] == 8'h00) : (res16 == 16'h0000);
    ea     = opa + (offset_en_in ? w_reg[src_b_sel_in] : 16'h0000);
  end

  // multiplier: word operands widened to 17 bits by sign mode, byte operands zero-extended
  always_comb begin
    if (byte_mode_in) begin
      mul_a = {9'h000, opa[7:0]};
      mul_b = {9'h000, opb[7:0]};
    end else begin
      mul_a = {(op == core_pkg::OP_MUL_SS || op == core_pkg::OP_MUL_SU) & opa[15], opa};
      mul_b = {(op == core_pkg::OP_MUL_SS || op == core_pkg::OP_MUL_US) & opb[15], opb};
    end
    prod = 34'($signed(mul_a) * $signed(mul_b));
  end

  // status flag update
  always_comb begin
    flags_next = flag_reg;
    if (go & is_arith) begin
      flags_next[`SR_C_BIT] = byte_mode_in ? sum_b[8] : sum_w[16];
      flags_next[`SR_DC_BIT] = byte_mode_in ? sum_n[4] : sum_b[8];
      flags_next[`SR_OV_BIT] = (a_msb == b_msb) & (r_msb != a_msb);
      flags_next[`SR_N_BIT] = r_msb;
      flags_next[`SR_Z_BIT] = is_chain ? (flag_reg[`SR_Z_BIT] & r_zero) : r_zero;
    end else if (go & is_logic) begin
      flags_next[`SR_N_BIT] = r_msb;
      flags_next[`SR_Z_BIT] = r_zero;
    end else if (sr_wr_in) begin
      flags_next[`SR_DC_BIT] = sr_wdata_in[`SR_DC_BIT];
      flags_next[3:0] = sr_wdata_in[3:0];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_reg <= 9'h000;
    end else begin
      flag_reg <= flags_next;
    end
  end

  // priority bits: exceptions raise them, software writes blocked by nesting disable
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ipl_reg <= 3'h0;
    end else if (trap_take) begin
      ipl_reg <= `IPL_USER_OFF;
    end else if (irq_take) begin
      ipl_reg <= irq_level_in;
    end else if (sr_wr_in & ~nesting_disable_in) begin
      ipl_reg <= sr_wdata_in[`SR_IPL_HI:`SR_IPL_LO];
    end
  end

  // divider runs while the core waits
  assign div_num = wide_div_in ? {w_reg[src_a_sel_in | 4'h1], w_reg[src_a_sel_in & 4'he]}
                 : (op == core_pkg::OP_DIV_S) ? {{16{opa[15]}}, opa} : {16'h0000, opa};

  div_nonrestore u_div (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .start_in    (go & is_div),
    .abort_in    (trap_take | irq_take),
    .signed_in   (op == core_pkg::OP_DIV_S),
    .dividend_in (div_num),
    .divisor_in  (opb),
    .done_out    (div_done),
    .quot_out    (div_q),
    .rem_out     (div_r)
  );

  // working register writes
  assign push = trap_take | irq_take | (go & (op == core_pkg::OP_BRANCH) & byte_mode_in);
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      w_we[k]   = 1'b0;
      w_next[k] = w_reg[k];
    end
    if (go & (is_arith | is_logic) & ~dst_mem_in) begin
      w_we[dst_sel_in]   = 1'b1;
      w_next[dst_sel_in] = byte_mode_in ? {w_reg[dst_sel_in][15:8], res16[7:0]} : res16;
    end
    if (go & is_mul) begin
      w_we[dst_sel_in & 4'he]   = 1'b1;
      w_next[dst_sel_in & 4'he] = prod[15:0];
      w_we[dst_sel_in | 4'h1]   = 1'b1;
      w_next[dst_sel_in | 4'h1] = prod[31:16];
    end
    if (div_done & (ex_state_reg == core_pkg::EX_DIVW)) begin
      w_we[0]   = 1'b1;
      w_next[0] = div_q;
      w_we[1]   = 1'b1;
      w_next[1] = div_r;
    end
    if (push) begin
      w_we[`SP_INDEX'(15)]   = 1'b1;
      w_next[`SP_INDEX'(15)] = w_reg[15] + `SP_STEP;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_wreg
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          w_reg[gi] <= `W_RESET;
        end else if (w_we[gi]) begin
          w_reg[gi] <= w_next[gi];
        end
      end
    end
  endgenerate

  // repeat loop: the looped instruction reissues with no extra cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rpt_active_reg <= 1'b0;
      rpt_cnt_reg    <= `RPT_RESET;
    end else if (trap_take | irq_take) begin
      rpt_active_reg <= 1'b0;
    end else if (go & (op == core_pkg::OP_REPEAT)) begin
      rpt_active_reg <= 1'b1;
      rpt_cnt_reg    <= opb;
    end else if (go & rpt_active_reg) begin
      if (rpt_cnt_reg == 16'h0000) begin
        rpt_active_reg <= 1'b0;
      end else begin
        rpt_cnt_reg <= rpt_cnt_reg - 16'h0001;
      end
    end
  end

  // execution sequencing and instruction pointer
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ex_state_reg <= core_pkg::EX_RUN;
      ip_reg       <= `IP_RESET;
    end else if (trap_take) begin
      ex_state_reg <= core_pkg::EX_BUBBLE;
      ip_reg <= `TRAP_VEC_BASE + {19'h0_0000, trap_idx, 1'b0};
    end else if (irq_take) begin
      ex_state_reg <= core_pkg::EX_BUBBLE;
      ip_reg <= `IRQ_VEC_BASE + {15'h0000, irq_src_in, 1'b0};
    end else begin
      unique case (ex_state_reg)
        core_pkg::EX_RUN: begin
          if (go & (op == core_pkg::OP_BRANCH)) begin
            ip_reg       <= branch_target_in;
            ex_state_reg <= core_pkg::EX_BUBBLE;
          end else if (go & is_div) begin
            ex_state_reg <= core_pkg::EX_DIVW;
          end else if (go & ~(rpt_active_reg & (rpt_cnt_reg != 16'h0000))) begin
            ip_reg <= ip_reg + `IP_STEP;
          end
        end
        core_pkg::EX_BUBBLE: ex_state_reg <= core_pkg::EX_RUN;
        core_pkg::EX_DIVW: begin
          if (div_done) begin
            ip_reg       <= ip_reg + `IP_STEP;
            ex_state_reg <= core_pkg::EX_RUN;
          end
        end
        default: ex_state_reg <= core_pkg::EX_RUN;
      endcase
    end
  end

  // program window page register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      page_reg <= `PAGE_RESET;
    end else if (prog_window_page_wr_in) begin
      page_reg <= prog_window_page_in;
    end
  end

  // data-side outputs: result write-back, stack pushes, program window
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      result_out        <= 16'h0000;
      mem_addr_out      <= 16'h0000;
      mem_we_out        <= 1'b0;
      mem_wdata_out     <= 16'h0000;
      psv_hit_out       <= 1'b0;
      psv_prog_addr_out <= `IP_RESET;
    end else begin
      mem_we_out  <= 1'b0;
      psv_hit_out <= 1'b0;
      if (push) begin
        mem_addr_out  <= w_reg[15];
        mem_we_out    <= 1'b1;
        mem_wdata_out <= (trap_take | irq_take) ? ip_reg[15:0] : ip_reg[15:0] + 16'h0001;
      end else if (go) begin
        result_out   <= is_mul ? prod[15:0] : res16;
        mem_addr_out <= ea;
        if (dst_mem_in & (is_arith | is_logic)) begin
          mem_we_out    <= 1'b1;
          mem_wdata_out <= res16;
        end
        if (psv_enable_in & ea[`PSV_SEL_BIT]) begin
          psv_hit_out       <= 1'b1;
          psv_prog_addr_out <= {page_reg, ea[14:0]};
        end
      end
    end
  end

  // status image and priority outputs
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      alu_status_flags_out    <= `SR_RESET;
      instruction_pointer_out <= `IP_RESET;
      stack_pointer_out       <= `W_RESET;
      eff_priority_out        <= 4'h0;
      user_irq_disable_out    <= 1'b0;
      stall_out               <= 1'b0;
      trap_ack_out            <= 1'b0;
      irq_ack_out             <= 1'b0;
    end else begin
      alu_status_flags_out <= {7'h00, flags_next[`SR_DC_BIT], ipl_reg,
                               rpt_active_reg, flags_next[3:0]};
      instruction_pointer_out <= ip_reg;
      stack_pointer_out       <= w_reg[15];
      eff_priority_out        <= eff_ipl;
      user_irq_disable_out    <= users_off;
      stall_out               <= ex_state_reg != core_pkg::EX_RUN;
      trap_ack_out            <= trap_take;
      irq_ack_out             <= irq_take;
    end
  end
endmodule : cpu_core_status_and_timing

// *** verilog/core_consts.svh ***
// constants for the cpu core status and timing block
// Operation
// - instruction pointer is 23 bits, counting whole instructions
// - single-cycle instructions except flow changes and divide
// - repeat loops add no per-iteration cost and yield to interrupts
// - sixteen 16-bit working registers usable as data, pointer or offset
// - last working register is the stack pointer for calls and interrupts
// - upper 32 Kbytes of data map to program memory via 8-bit page
// - data read, register read, data write and fetch all in one cycle
// - 17x17 multiplier: signed, unsigned, mixed 16x16 or unsigned 8x8; one cycle
// - non-restoring divide, signed/unsigned 32/16 and 16/16, 19 cycles, interruptible
// - vectored: 8 non-maskable traps, 118 interrupts, seven priority levels
// - status bits 15..9 read zero; implemented bits reset to zero
// - half carry from bit 3 in byte ops, bit 7 in word ops
// - status bits 7..5 hold priority 0..7; 7 blocks user interrupts
// - effective priority is extension bit above the three priority bits
// - priority bits ignore writes while nesting disable is set
// - repeat-active bit 4 reads one while a repeat loop runs
// - negative flag bit 3 follows the result sign
// - overflow flag bit 2 marks signed overflow
// - zero flag bit 1 cleared by nonzero result, sticky in carry chains
// - carry flag bit 0 is carry out of result msb
// - for subtraction carry and half carry are inverted borrows
// - extension bit set disables all user interrupts
`ifndef CORE_CONSTS_SVH
`define CORE_CONSTS_SVH
`define IP_W            23
`define IP_RESET        23'h00_0000
`define IP_STEP         23'h00_0001
`define TRAP_VEC_BASE   23'h00_0004
`define IRQ_VEC_BASE    23'h00_0014
`define SR_RESET        16'h0000
`define SR_DC_BIT       8
`define SR_IPL_HI       7
`define SR_IPL_LO       5
`define SR_RA_BIT       4
`define SR_N_BIT        3
`define SR_OV_BIT       2
`define SR_Z_BIT        1
`define SR_C_BIT        0
`define IPL_USER_OFF    3'h7
`define IRQ_SRC_COUNT   7'h76
`define SP_INDEX        4
`define SP_STEP         16'h0002
`define W_RESET         16'h0000
`define PSV_SEL_BIT     15
`define PAGE_RESET      8'h00
`define DIV_CYCLES      5'h13
`define DIV_ITERS       5'h10
`define RPT_RESET       16'h0000
`endif

// *** verilog/core_pkg.sv ***
// types shared by the cpu core files
package core_pkg;
  typedef enum logic [3:0] {
    OP_ADD    = 4'h0,
    OP_ADDC   = 4'h1,
    OP_SUB    = 4'h2,
    OP_SUBB   = 4'h3,
    OP_AND    = 4'h4,
    OP_IOR    = 4'h5,
    OP_XOR    = 4'h6,
    OP_MOV    = 4'h7,
    OP_MUL_UU = 4'h8,
    OP_MUL_SS = 4'h9,
    OP_MUL_SU = 4'ha,
    OP_MUL_US = 4'hb,
    OP_DIV_U  = 4'hc,
    OP_DIV_S  = 4'hd,
    OP_REPEAT = 4'he,
    OP_BRANCH = 4'hf
  } op_t;

  typedef enum logic [1:0] {
    EX_RUN    = 2'b00,
    EX_BUBBLE = 2'b01,
    EX_DIVW   = 2'b11
  } exec_state_t;

  typedef enum logic [2:0] {
    DV_IDLE = 3'b000,
    DV_LOAD = 3'b001,
    DV_ITER = 3'b011,
    DV_FIX  = 3'b010,
    DV_SIGN = 3'b110
  } div_state_t;
endpackage : core_pkg

// *** verilog/div_nonrestore.sv ***
// iterative non-restoring 32/16 divider
`timescale 1ns/1ps
`include "core_consts.svh"
module div_nonrestore (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic        abort_in,
  input  wire logic        signed_in,
  input  wire logic [31:0] dividend_in,
  input  wire logic [15:0] divisor_in,
  output logic             done_out,
  output logic [15:0]      quot_out,
  output logic [15:0]      rem_out
);
  core_pkg::div_state_t state_reg;
  logic [4:0]  iter_reg;
  logic [17:0] rem_reg;
  logic [15:0] quo_reg;
  logic [31:0] num_reg;
  logic [15:0] den_reg;
  logic        qneg_reg;
  logic        rneg_reg;
  logic [17:0] shifted;
  logic [17:0] stepped;
  logic [17:0] rem_fix;
  logic [31:0] num_abs;

  // 18-bit remainder: divisors above 0x7fff must not overflow it
  always_comb begin
    shifted = {rem_reg[16:0], quo_reg[15]};
    stepped = rem_reg[17] ? shifted + {2'b00, den_reg} : shifted - {2'b00, den_reg};
    rem_fix = rem_reg[17] ? rem_reg + {2'b00, den_reg} : rem_reg;
    num_abs = rneg_reg ? -num_reg : num_reg;
  end

  // start, load, 16 iterations, fix and sign: result ready on the 19th edge
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= core_pkg::DV_IDLE;
      iter_reg  <= 5'h00;
      rem_reg   <= 18'h0_0000;
      quo_reg   <= 16'h0000;
      num_reg   <= 32'h0000_0000;
      den_reg   <= 16'h0000;
      qneg_reg  <= 1'b0;
      rneg_reg  <= 1'b0;
      done_out  <= 1'b0;
      quot_out  <= 16'h0000;
      rem_out   <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      if (abort_in) begin
        state_reg <= core_pkg::DV_IDLE;
      end else begin
        unique case (state_reg)
          core_pkg::DV_IDLE: begin
            if (start_in) begin
              num_reg   <= dividend_in;
              den_reg   <= divisor_in;
              qneg_reg  <= signed_in & (dividend_in[31] ^ divisor_in[15]);
              rneg_reg  <= signed_in & dividend_in[31];
              state_reg <= core_pkg::DV_LOAD;
            end
          end
          core_pkg::DV_LOAD: begin
            rem_reg <= {2'b00, num_abs[31:16]};
            quo_reg <= num_abs[15:0];
            if (qneg_reg ^ rneg_reg) begin
              den_reg <= -den_reg;
            end
            iter_reg  <= 5'h00;
            state_reg <= core_pkg::DV_ITER;
          end
          core_pkg::DV_ITER: begin
            rem_reg  <= stepped;
            quo_reg  <= {quo_reg[14:0], ~stepped[17]};
            iter_reg <= iter_reg + 5'h01;
            if (iter_reg == `DIV_ITERS - 5'h01) begin
              state_reg <= core_pkg::DV_FIX;
            end
          end
          core_pkg::DV_FIX: begin
            quot_out  <= qneg_reg ? -quo_reg : quo_reg;
            rem_out   <= rneg_reg ? -rem_fix[15:0] : rem_fix[15:0];
            done_out  <= 1'b1;
            state_reg <= core_pkg::DV_IDLE;
          end
          default: state_reg <= core_pkg::DV_IDLE;
        endcase
      end
    end
  end
endmodule : div_nonrestore

// *** dv/cpu_core_status_and_timing_monitor.sv ***
// port assertions for the cpu core status and timing block
`timescale 1ns/1ps
`include "core_consts.svh"
module cpu_core_status_and_timing_monitor (
  input wire logic             mclk_in,
  input wire logic             rst_in,
  input wire logic             sr_wr_in,
  input wire logic             nesting_disable_in,
  input wire logic [7:0]       trap_req_in,
  input wire logic             irq_req_in,
  input wire logic [`IP_W-1:0] instruction_pointer_out,
  input wire logic [15:0]      alu_status_flags_out,
  input wire logic [15:0]      stack_pointer_out,
  input wire logic [15:0]      mem_addr_out,
  input wire logic             mem_we_out,
  input wire logic             psv_hit_out,
  input wire logic [3:0]       eff_priority_out,
  input wire logic             user_irq_disable_out,
  input wire logic             stall_out,
  input wire logic             trap_ack_out,
  input wire logic             irq_ack_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [4:0] stall_cnt;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      stall_cnt <= 5'h0;
    end else if (stall_out) begin
      stall_cnt <= stall_cnt + 5'h1;
    end else begin
      stall_cnt <= 5'h0;
    end
  end
  unused_zero_a: assert property (alu_status_flags_out[15:9] == 7'h00)
    else $error("status upper bits not zero");
  prio_concat_a: assert property (eff_priority_out[2:0] == alu_status_flags_out[7:5])
    else $error("effective priority low bits differ from status");
  user_off_a: assert property (
    user_irq_disable_out == (eff_priority_out[3] || eff_priority_out[2:0] == 3'h7))
    else $error("user interrupt disable wrong");
  nest_lock_a: assert property (nesting_disable_in && sr_wr_in && !irq_req_in
    && trap_req_in == 8'h00 |-> ##2 $stable(alu_status_flags_out[7:5]))
    else $error("priority bits written while locked");
  div_len_a: assert property (stall_cnt <= 5'h13)
    else $error("stall longer than divide time");
  psv_top_a: assert property (psv_hit_out |-> mem_addr_out[15])
    else $error("program window hit below upper half");
  push_sp_a: assert property (trap_ack_out || irq_ack_out |-> mem_we_out
    ##1 stack_pointer_out == mem_addr_out + 16'h0002)
    else $error("exception push does not match stack pointer");
  trap_vec_a: assert property (trap_ack_out |-> ##1
    instruction_pointer_out inside {[23'h00_0004:23'h00_0012]})
    else $error("trap vector out of range");
  irq_vec_a: assert property (irq_ack_out |-> ##1
    instruction_pointer_out inside {[23'h00_0014:23'h00_0100]})
    else $error("interrupt vector out of range");
  cover property (trap_ack_out);
  cover property (irq_ack_out);
  cover property (psv_hit_out);
  cover property (stall_cnt > 5'h8);
endmodule : cpu_core_status_and_timing_monitor

// *** dv/cpu_core_status_and_timing_tb_top.sv ***
// self-checking testbench for the cpu core status and timing block
`timescale 1ns/1ps
`include "core_consts.svh"
module cpu_core_status_and_timing_tb_top;
  logic mclk_in = 1'b0, rst_in = 1'b1, op_valid_in = 1'b0, byte_mode_in = 1'b0;
  logic wide_div_in = 1'b0, src_b_mem_in = 1'b0, dst_mem_in = 1'b0, offset_en_in = 1'b0;
  logic sr_wr_in = 1'b0, nesting_disable_in = 1'b0, priority_extend_in = 1'b0;
  logic psv_enable_in = 1'b0, prog_window_page_wr_in = 1'b0, irq_req_in = 1'b0;
  logic [3:0] op_code_in = 4'h0, dst_sel_in = 4'h0, src_a_sel_in = 4'h0, src_b_sel_in = 4'h0;
  logic [15:0] mem_rdata_in = 16'h0000, sr_wdata_in = 16'h0000;
  logic [7:0] prog_window_page_in = 8'h00, trap_req_in = 8'h00;
  logic [6:0] irq_src_in = 7'h00;
  logic [2:0] irq_level_in = 3'h0;
  logic [`IP_W-1:0] branch_target_in = 23'h00_0000;
  logic [`IP_W-1:0] instruction_pointer_out, psv_prog_addr_out;
  logic [15:0] alu_status_flags_out, stack_pointer_out, result_out, mem_addr_out, mem_wdata_out;
  logic [3:0] eff_priority_out;
  logic mem_we_out, psv_hit_out, user_irq_disable_out, stall_out, trap_ack_out, irq_ack_out;
  logic psv_seen;
  int err_count = 0;
  int n_compared = 0;

  cpu_core_status_and_timing DUT (.*);

  always #20 mclk_in = ~mclk_in;

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [22:0] got, input logic [22:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick

  task automatic op(input logic [3:0] c, input logic [3:0] d, input logic [3:0] a,
                    input logic [3:0] b, input logic m, input logic [15:0] rd);
    @(posedge mclk_in);
    op_valid_in  <= 1'b1;
    op_code_in   <= c;
    dst_sel_in   <= d;
    src_a_sel_in <= a;
    src_b_sel_in <= b;
    src_b_mem_in <= m;
    mem_rdata_in <= rd;
    @(posedge mclk_in);
    op_valid_in <= 1'b0;
    #1;
    psv_seen = psv_hit_out;
    tick(1);
  endtask : op

  task automatic srw(input logic [15:0] d);
    @(posedge mclk_in);
    sr_wr_in    <= 1'b1;
    sr_wdata_in <= d;
    @(posedge mclk_in);
    sr_wr_in <= 1'b0;
    tick(1);
  endtask : srw

  task automatic t_alu;
    op(core_pkg::OP_MOV, 4'h1, 4'h0, 4'h0, 1'b1, 16'h7fff);
    op(core_pkg::OP_MOV, 4'h2, 4'h0, 4'h0, 1'b1, 16'h0001);
    op(core_pkg::OP_ADD, 4'h3, 4'h1, 4'h2, 1'b0, 16'h0000);
    chk(result_out, 16'h8000);
    chk(alu_status_flags_out, 16'h010c);
    chk(instruction_pointer_out, 23'h00_0003);
    op(core_pkg::OP_SUB, 4'h6, 4'h2, 4'h0, 1'b1, 16'h0001);
    chk(alu_status_flags_out, 16'h0103);
    op(core_pkg::OP_ADD, 4'h6, 4'h3, 4'h0, 1'b1, 16'h8000);
    chk(alu_status_flags_out, 16'h0007);
  endtask : t_alu

  task automatic t_mul_div;
    int n;
    op(core_pkg::OP_MUL_UU, 4'h8, 4'h1, 4'h1, 1'b0, 16'h0000);
    chk(result_out, 16'h0001);
    chk(stall_out, 1'b0);
    op(core_pkg::OP_MOV, 4'h7, 4'h0, 4'h9, 1'b0, 16'h0000);
    chk(result_out, 16'h3fff);
    op(core_pkg::OP_MOV, 4'h5, 4'h0, 4'h0, 1'b1, 16'h0010);
    op(core_pkg::OP_DIV_U, 4'h0, 4'h1, 4'h5, 1'b0, 16'h0000);
    chk(stall_out, 1'b1);
    for (n = 0; n < 40 && stall_out === 1'b1; n++) begin
      tick(1);
    end
    chk(23'(n), 23'h00_0013);
    if (stall_out !== 1'b0) begin
      err_count++;
      print_verdict();
    end
    op(core_pkg::OP_MOV, 4'h7, 4'h0, 4'h0, 1'b0, 16'h0000);
    chk(result_out, 16'h07ff);
    op(core_pkg::OP_MOV, 4'h7, 4'h0, 4'h1, 1'b0, 16'h0000);
    chk(result_out, 16'h000f);
  endtask : t_mul_div

  task automatic t_psv;
    @(posedge mclk_in);
    psv_enable_in          <= 1'b1;
    prog_window_page_wr_in <= 1'b1;
    prog_window_page_in    <= 8'h05;
    @(posedge mclk_in);
    prog_window_page_wr_in <= 1'b0;
    op(core_pkg::OP_MOV, 4'h7, 4'h3, 4'h0, 1'b1, 16'h1234);
    chk(psv_seen, 1'b1);
    chk(psv_prog_addr_out, 23'h02_8000);
  endtask : t_psv

  task automatic t_prio;
    srw(16'h00a0);
    chk(alu_status_flags_out, 16'h00a0);
    chk(eff_priority_out, 4'h5);
    chk(user_irq_disable_out, 1'b0);
    @(posedge mclk_in);
    priority_extend_in <= 1'b1;
    tick(2);
    chk(eff_priority_out, 4'hd);
    chk(user_irq_disable_out, 1'b1);
    @(posedge mclk_in);
    priority_extend_in <= 1'b0;
    nesting_disable_in <= 1'b1;
    srw(16'h0000);
    chk(alu_status_flags_out, 16'h00a0);
    @(posedge mclk_in);
    nesting_disable_in <= 1'b0;
  endtask : t_prio

  task automatic t_exc(input logic [7:0] trap, input logic [2:0] lvl, input logic ack,
                       input logic [22:0] ip, input logic [15:0] sp, input logic [15:0] sr,
                       input logic [15:0] ret);
    @(posedge mclk_in);
    trap_req_in  <= trap;
    irq_req_in   <= (trap == 8'h00);
    irq_src_in   <= 7'h02;
    irq_level_in <= lvl;
    @(posedge mclk_in);
    trap_req_in <= 8'h00;
    irq_req_in  <= 1'b0;
    #1;
    chk(trap_ack_out | irq_ack_out, ack);
    chk(mem_we_out, ack);
    chk(mem_wdata_out, ret);
    tick(1);
    chk(instruction_pointer_out, ip);
    chk(stack_pointer_out, sp);
    chk(alu_status_flags_out, sr);
  endtask : t_exc

  task automatic t_rpt;
    op(core_pkg::OP_REPEAT, 4'h0, 4'h0, 4'h2, 1'b0, 16'h0000);
    op(core_pkg::OP_ADD, 4'h4, 4'h4, 4'h2, 1'b0, 16'h0000);
    chk(alu_status_flags_out, 16'h00f0);
    chk(instruction_pointer_out, 23'h00_0009);
    op(core_pkg::OP_ADD, 4'h4, 4'h4, 4'h2, 1'b0, 16'h0000);
    chk(result_out, 16'h0002);
    chk(alu_status_flags_out, 16'h00e0);
  endtask : t_rpt

  task automatic t_branch;
    @(posedge mclk_in);
    branch_target_in <= 23'h7f_fffe;
    op(core_pkg::OP_BRANCH, 4'h0, 4'h0, 4'h0, 1'b0, 16'h0000);
    chk(instruction_pointer_out, 23'h7f_fffe);
    op(core_pkg::OP_AND, 4'ha, 4'h0, 4'h0, 1'b0, 16'h0000);
    chk(instruction_pointer_out, 23'h7f_ffff);
  endtask : t_branch

  initial begin
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    tick(1);
    chk(alu_status_flags_out, 16'h0000);
    chk(instruction_pointer_out, 23'h00_0000);
    t_alu();
    t_mul_div();
    t_psv();
    t_prio();
    t_exc(8'h00, 3'h3, 1'b0, 23'h00_000c, 16'h0000, 16'h00a0, 16'h0000);
    t_exc(8'h00, 3'h6, 1'b1, 23'h00_0018, 16'h0002, 16'h00c0, 16'h000c);
    t_exc(8'h0c, 3'h0, 1'b1, 23'h00_0008, 16'h0004, 16'h00e0, 16'h0018);
    t_rpt();
    t_branch();
    print_verdict();
  end
endmodule : cpu_core_status_and_timing_tb_top

bind cpu_core_status_and_timing cpu_core_status_and_timing_monitor u_mon (.*);
